// ==== logic/smpm_gpio_pad.sv ====
// One general purpose pad: push-pull, open-drain or input
`timescale 1ns/1ps
module smpm_gpio_pad
	import smpm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Configuration
	input wire logic [1:0] cfg_i,
	input wire logic dout_i,
	// Pad
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe_o,
	// Core side
	output logic din_o
);

	logic din_q;

	always_comb begin
		pad_o = 1'b0;
		pad_oe_o = 1'b0;
		case (cfg_i)
			SMPM_GP_PP: begin
				pad_o = dout_i;
				pad_oe_o = 1'b1;
			end
			SMPM_GP_OD: begin
				pad_o = 1'b0;
				pad_oe_o = ~dout_i;
			end
			default: begin
				pad_o = 1'b0;
				pad_oe_o = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			din_q <= 1'b0;
		end else if (cfg_i == SMPM_GP_IN) begin
			din_q <= pad_i;
		end else begin
			din_q <= 1'b0;
		end
	end

	assign din_o = din_q;

endmodule

// ==== logic/smpm_pkg.sv ====
// Package for the serial management pin mux: modes, carriers, constants
package smpm_pkg;

	// ----------------------------------------
	// Management modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		SMPM_MODE_SPI = 2'h0,
		SMPM_MODE_I2C = 2'h1,
		SMPM_MODE_EXT = 2'h3,
		SMPM_MODE_UNMANAGED = 2'h2
	} smpm_mode_t;

	// ----------------------------------------
	// Strap capture sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		SMPM_ST_RESET = 2'h0,
		SMPM_ST_CAPTURE = 2'h1,
		SMPM_ST_RUN = 2'h3
	} smpm_state_t;

	localparam int SMPM_STRAP_W = 8;
	localparam int SMPM_NUM_UGPIO = 4;
	localparam int SMPM_NUM_LGPIO = 8;
	localparam logic [SMPM_STRAP_W-1:0] SMPM_STRAP_RST = 8'h00;
	localparam smpm_mode_t SMPM_MODE_RST = SMPM_MODE_UNMANAGED;
	// Strap capture window length, in cycles after reset release
	localparam logic [3:0] SMPM_CAPTURE_CYC = 4'h4;

	// GPIO pin configuration
	localparam logic [1:0] SMPM_GP_IN = 2'h0;
	localparam logic [1:0] SMPM_GP_PP = 2'h1;
	localparam logic [1:0] SMPM_GP_OD = 2'h2;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic sck;
		logic sdi;
		logic select_n;
	} smpm_spi_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} smpm_i2c_t;

	typedef struct packed {
		logic polarity_high;
		logic open_drain;
		logic enable;
	} smpm_irq_cfg_t;

	typedef struct packed {
		smpm_state_t state;
		logic [3:0] count;
		smpm_mode_t mode;
		logic [SMPM_STRAP_W-1:0] straps;
	} smpm_reg_t;

endpackage

// ==== logic/smpm_top.sv ====
// Serial management pin mux: mode steering, straps, GPIO and IRQ pads
//
// Function
// - Data pin: SPI input or I2C open-drain
// - Clock pin: SPI or I2C clock input
// - Other modes ignore data and clock pins
// - SPI output driven low outside SPI mode
// - SPI transfers accepted only while selected
// - SPI output tri-stated while select high
// - Select ignored outside SPI mode
// - Straps latched on the fifth clock after reset release
// - Strap sampling only during capture window
// - Upper GPIOs: push-pull, open-drain or input
// - Upper GPIO input buffer only when input
// - Lower GPIOs share pins with LEDs
// - IRQ source and buffer selectable; polarity selectable in push-pull only
// - External or power-on reset resets device
`timescale 1ns/1ps
module smpm_top
	import smpm_pkg::*;
(
	// Clock and resets
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ext_reset_n_i,
	// Strap pins and mode strap
	input wire logic [SMPM_STRAP_W-1:0] strap_pins_i,
	input wire smpm_mode_t mode_strap_i,
	// Shared management pins
	input wire logic mgmt_data_i,
	output logic mgmt_data_o,
	output logic mgmt_data_oe_o,
	input wire logic mgmt_clk_i,
	input wire logic spi_select_n_i,
	output logic spi_dout_o,
	output logic spi_dout_oe_o,
	// Core side serial engines
	output smpm_spi_t spi_core_o,
	output smpm_i2c_t i2c_core_o,
	input wire logic spi_core_dout_i,
	input wire logic i2c_core_sda_low_i,
	// Upper GPIOs
	input wire logic [2*SMPM_NUM_UGPIO-1:0] ugpio_cfg_i,
	input wire logic [SMPM_NUM_UGPIO-1:0] ugpio_dout_i,
	input wire logic [SMPM_NUM_UGPIO-1:0] ugpio_pad_i,
	output logic [SMPM_NUM_UGPIO-1:0] ugpio_pad_o,
	output logic [SMPM_NUM_UGPIO-1:0] ugpio_pad_oe_o,
	output logic [SMPM_NUM_UGPIO-1:0] ugpio_din_o,
	// Lower GPIO / LED shared pins
	input wire logic [SMPM_NUM_LGPIO-1:0] lgpio_led_sel_i,
	input wire logic [SMPM_NUM_LGPIO-1:0] led_i,
	input wire logic [SMPM_NUM_LGPIO-1:0] lgpio_dout_i,
	input wire logic [SMPM_NUM_LGPIO-1:0] lgpio_oe_i,
	output logic [SMPM_NUM_LGPIO-1:0] lgpio_pad_o,
	output logic [SMPM_NUM_LGPIO-1:0] lgpio_pad_oe_o,
	// Interrupt
	input wire logic [1:0] irq_sources_i,
	input wire logic irq_source_sel_i,
	input wire smpm_irq_cfg_t irq_cfg_i,
	output logic irq_pad_o,
	output logic irq_pad_oe_o,
	// Status
	output smpm_mode_t mode_o,
	output logic [SMPM_STRAP_W-1:0] straps_o,
	output logic ready_o
);

	smpm_reg_t r_q;
	smpm_reg_t r_d;
	logic chip_rstn;
	logic is_spi;
	logic is_i2c;
	logic irq_active;

	// ----------------------------------------
	// Chip-level reset
	// ----------------------------------------
	// Either reset source
	assign chip_rstn = rstn_i & ext_reset_n_i;

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		case (r_q.state)
			SMPM_ST_RESET: begin
				r_d.state = SMPM_ST_CAPTURE;
				r_d.count = 4'h0;
			end
			SMPM_ST_CAPTURE: begin
				r_d.count = r_q.count + 4'h1;
				if (r_q.count == SMPM_CAPTURE_CYC - 4'h1) begin
					r_d.straps = strap_pins_i;
					r_d.mode = mode_strap_i;
					r_d.state = SMPM_ST_RUN;
				end
			end
			SMPM_ST_RUN: begin
				r_d = r_q;
			end
			default: begin
				r_d.state = SMPM_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!chip_rstn) begin
			r_q <= '{state: SMPM_ST_RESET, count: 4'h0, mode: SMPM_MODE_RST,
				straps: SMPM_STRAP_RST};
		end else begin
			r_q <= r_d;
		end
	end

	assign mode_o = r_q.mode;
	assign straps_o = r_q.straps;
	assign ready_o = (r_q.state == SMPM_ST_RUN);

	// ----------------------------------------
	// Serial management steering
	// ----------------------------------------
	// Pins idle until straps valid
	assign is_spi = ready_o && (r_q.mode == SMPM_MODE_SPI);
	assign is_i2c = ready_o && (r_q.mode == SMPM_MODE_I2C);

	always_comb begin
		spi_core_o = '{sck: 1'b1, sdi: 1'b1, select_n: 1'b1};
		i2c_core_o = '{scl: 1'b1, sda: 1'b1};
		if (is_spi) begin
			spi_core_o.sck = mgmt_clk_i;
			spi_core_o.sdi = mgmt_data_i;
			spi_core_o.select_n = spi_select_n_i;
		end
		if (is_i2c) begin
			i2c_core_o.scl = mgmt_clk_i;
			i2c_core_o.sda = mgmt_data_i;
		end
	end

	assign mgmt_data_o = 1'b0;
	assign mgmt_data_oe_o = is_i2c & i2c_core_sda_low_i;

	always_comb begin
		spi_dout_o = 1'b0;
		spi_dout_oe_o = 1'b1;
		if (is_spi) begin
			spi_dout_o = spi_core_dout_i;
			spi_dout_oe_o = ~spi_select_n_i;
		end
	end

	// ----------------------------------------
	// GPIO pads
	// ----------------------------------------
	for (genvar g = 0; g < SMPM_NUM_UGPIO; g++) begin : g_ugpio
		smpm_gpio_pad u_pad (
			.clk_i(clk_i),
			.rstn_i(chip_rstn),
			.cfg_i(ugpio_cfg_i[2*g+:2]),
			.dout_i(ugpio_dout_i[g]),
			.pad_i(ugpio_pad_i[g]),
			.pad_o(ugpio_pad_o[g]),
			.pad_oe_o(ugpio_pad_oe_o[g]),
			.din_o(ugpio_din_o[g])
		);
	end

	always_comb begin
		for (int i = 0; i < SMPM_NUM_LGPIO; i++) begin
			lgpio_pad_o[i] = lgpio_led_sel_i[i] ? led_i[i] : lgpio_dout_i[i];
			lgpio_pad_oe_o[i] = lgpio_led_sel_i[i] | lgpio_oe_i[i];
		end
	end

	// ----------------------------------------
	// Interrupt pad
	// ----------------------------------------
	// Source, polarity, buffer select
	assign irq_active = irq_cfg_i.enable & irq_sources_i[irq_source_sel_i];

	always_comb begin
		if (irq_cfg_i.open_drain) begin
			irq_pad_o = 1'b0;
			irq_pad_oe_o = irq_active;
		end else begin
			irq_pad_o = irq_cfg_i.polarity_high ? irq_active : ~irq_active;
			irq_pad_oe_o = 1'b1;
		end
	end

endmodule

// ==== verification/smpm_host.sv ====
// Host controller model on the shared management pins
`timescale 1ns/1ps
module smpm_host (
	// Clock and request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic sda_low_i,
	// Pins
	output logic sel_n_o,
	output logic sck_o,
	output logic sd_o
);
	logic [4:0] n_q = 5'h00;
	assign sel_n_o = n_q == 5'h00;
	// Released lines float to the pull-ups
	assign sck_o = sel_n_o | n_q[0];
	assign sd_o = (sel_n_o | n_q[2] ^ n_q[4]) & !sda_low_i;
	always_ff @(posedge clk_i) n_q <= go_i & sel_n_o ? 5'h10 : n_q - {4'h0, !sel_n_o};
endmodule

// ==== verification/smpm_props.sv ====
// Checker for the serial management pin mux
`timescale 1ns/1ps
module smpm_props
	import smpm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ext_reset_n_i,
	// Pins and status
	input wire logic [SMPM_STRAP_W-1:0] strap_pins_i,
	input wire logic mgmt_data_i,
	input wire logic mgmt_clk_i,
	input wire logic spi_select_n_i,
	input wire logic spi_dout_o,
	input wire logic spi_dout_oe_o,
	input wire smpm_spi_t spi_core_o,
	input wire smpm_i2c_t i2c_core_o,
	input wire smpm_mode_t mode_o,
	input wire logic [SMPM_STRAP_W-1:0] straps_o,
	input wire logic ready_o
);
	wire logic spi = ready_o && mode_o == SMPM_MODE_SPI;
	wire logic i2c = ready_o && mode_o == SMPM_MODE_I2C;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	AST_SDO_LOW: assert property (ready_o && !spi |-> !spi_dout_o && spi_dout_oe_o)
		else $error("sdo not low");
	AST_SDO_HIZ: assert property (spi && spi_select_n_i |-> !spi_dout_oe_o)
		else $error("sdo not off");
	AST_SPI_IN: assert property (
		spi |-> spi_core_o == {mgmt_clk_i, mgmt_data_i, spi_select_n_i}) else $error("spi path");
	AST_I2C_IN: assert property (
		i2c |-> i2c_core_o == {mgmt_clk_i, mgmt_data_i} && &spi_core_o) else $error("i2c path");
	AST_IDLE: assert property (ready_o && mode_o[1] |-> &{spi_core_o, i2c_core_o})
		else $error("idle pins");
	AST_LATCH: assert property (
		$rose(ready_o) |-> straps_o == $past(strap_pins_i) && $past(rstn_i, 4)) else $error("latch");
	AST_HOLD: assert property (ready_o && $past(ready_o) |-> $stable({mode_o, straps_o}))
		else $error("mode moved");
	AST_RST: assert property (
		disable iff (1'b0) !rstn_i |=> !ready_o && mode_o == SMPM_MODE_RST) else $error("reset");
	AST_EXT_RST: assert property (
		disable iff (1'b0) !ext_reset_n_i |=> !ready_o && mode_o == SMPM_MODE_RST)
		else $error("ext reset");
	cover property ($rose(ready_o) && spi);
	cover property (spi && !spi_select_n_i);
	cover property (i2c && !mgmt_data_i);
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial management pin mux
`timescale 1ns/1ps
module tb_top
	import smpm_pkg::*;
;
	logic clk_i = 1'b0, rstn_i = 1'b0, ext_reset_n_i = 1'b1, go = 1'b0;
	logic [6:0] n = 7'h00;
	logic [7:0] strap_pins_i = 8'h00, straps_o, lgpio_pad_o, lgpio_pad_oe_o;
	logic [3:0] ugpio_pad_o, ugpio_pad_oe_o, ugpio_din_o;
	logic mgmt_data_o, mgmt_data_oe_o, spi_dout_o, spi_dout_oe_o, irq_pad_o, irq_pad_oe_o, ready_o;
	wire logic mgmt_data_i, mgmt_clk_i, spi_select_n_i;
	wire logic [5:0] c = n[6:1];
	wire logic spi_core_dout_i = c[0], i2c_core_sda_low_i = c[1], irq_source_sel_i = c[0];
	wire logic [7:0] ugpio_cfg_i = {4{c[1:0]}}, lgpio_led_sel_i = {2{c[5:2]}}, led_i = {c, 2'h1};
	wire logic [7:0] lgpio_dout_i = {c[2:0], c[5:1]}, lgpio_oe_i = {8{c[1]}};
	wire logic [3:0] ugpio_dout_i = c[5:2], ugpio_pad_i = c[3:0];
	wire logic [1:0] irq_sources_i = c[5:4];
	wire smpm_irq_cfg_t irq_cfg_i = c[4:2];
	wire logic a = c[2] & irq_sources_i[irq_source_sel_i];
	smpm_mode_t mode_strap_i = SMPM_MODE_SPI, mode_o, m = SMPM_MODE_SPI;
	smpm_spi_t spi_core_o;
	smpm_i2c_t i2c_core_o;
	int err_total = 0, check_count = 0;
	smpm_top dut_u (.*);
	smpm_host host_u (.clk_i, .go_i(go), .sda_low_i(mgmt_data_oe_o), .sel_n_o(spi_select_n_i),
		.sck_o(mgmt_clk_i), .sd_o(mgmt_data_i));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) n <= n + 7'h01;
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Checks on the settled second cycle of each input step
	always @(negedge clk_i) if (n[0] && ready_o) begin
		chk({mode_o, straps_o}, {m, 6'h2c, m});
		if (m == SMPM_MODE_SPI) chk({spi_core_o, spi_dout_oe_o, spi_dout_o & spi_dout_oe_o},
			{mgmt_clk_i, mgmt_data_i, spi_select_n_i, !spi_select_n_i, c[0] & !spi_select_n_i});
		else chk({spi_core_o, spi_dout_oe_o, spi_dout_o}, 5'h1e);
		if (m == SMPM_MODE_I2C) chk({i2c_core_o, mgmt_data_oe_o, mgmt_data_o},
			{mgmt_clk_i, mgmt_data_i, c[1], 1'b0});
		else chk({i2c_core_o, mgmt_data_oe_o, mgmt_data_o}, 4'hc);
		chk({ugpio_pad_oe_o, ugpio_din_o, ugpio_pad_o & ugpio_pad_oe_o},
			c[1:0] == 2'h0 ? {8'h00, c[3:0], 4'h0} : c[1:0] == 2'h1 ? {8'hf0, c[5:2]} :
			{c[0] ? 4'h0 : ~c[5:2], 8'h00});
		chk({irq_pad_oe_o, irq_pad_o}, c[3] ? {a, 1'b0} : {1'b1, a ^ !c[4]});
		chk({lgpio_pad_o, lgpio_pad_oe_o}, {led_i & lgpio_led_sel_i |
			lgpio_dout_i & ~lgpio_led_sel_i, lgpio_oe_i | lgpio_led_sel_i});
	end
	initial begin
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_i);
			mode_strap_i <= smpm_mode_t'(k);
			strap_pins_i <= {6'h2c, 2'(k)};
			if (k[0]) ext_reset_n_i <= 1'b0;
			else rstn_i <= 1'b0;
			repeat (12) @(posedge clk_i);
			rstn_i <= 1'b1;
			ext_reset_n_i <= 1'b1;
			m <= smpm_mode_t'(k);
			for (int i = 0; i < 20 && ready_o !== 1'b1; i++) @(posedge clk_i);
			if (ready_o !== 1'b1) begin
				err_total++;
				test_done();
			end
			@(posedge clk_i);
			strap_pins_i <= ~strap_pins_i;
			mode_strap_i <= smpm_mode_t'(~k);
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			repeat (130) @(posedge clk_i);
			$display("mode %0d test done", k);
		end
		test_done();
	end
endmodule
bind smpm_top smpm_props props_u (.*);
